/* smsw_pkg.sv */
// smsw_pkg: constants and carriers for the switch monitor sleep/wake sequencer
// assumes a 100 MHz core clock and a host-driven serial clock sampled as data
package smsw_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int CHAIN_DEVICES = 2;
  localparam int CHAIN_CLOCKS = FRAME_BITS * CHAIN_DEVICES;
  localparam int NUM_GND = 14;
  localparam int NUM_PROG = 8;
  localparam int NUM_SW = NUM_GND + NUM_PROG;
  // command byte in the top bits of the frame; arbitrary neutral encoding
  localparam logic [7:0] CMD_LOW_POWER = 8'h5a;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 16;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_SWITCH = 2'h1;
  localparam logic [1:0] CAUSE_SHARED = 2'h2;
  localparam logic [1:0] CAUSE_SELECT = 2'h3;
  localparam logic TRISTATE_RESET = 1'b1;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } smsw_serial_t;

  typedef struct packed {
    logic [NUM_GND-1:0] ground_switch_input;
    logic [NUM_PROG-1:0] programmable_switch_input;
  } smsw_switch_t;

  typedef enum logic [1:0] {
    SMSW_NORMAL = 2'b01,
    SMSW_LOW_POWER = 2'b10
  } smsw_mode_t;
endpackage

/* smsw_seq.sv */
// smsw_seq: low-power entry, shared wake line and wake-cause flag of a switch monitor
// assumes serial pins, switch levels and the wake net are asynchronous to i_ref_clk
// How it works
// R1: with logic supply up and host down, a chip-select fall forces normal mode.
// R2: with logic supply absent, serial activity never wakes the device.
// R3: parallel-wired hosts select each device alone, so sleep reaches them at different times.
// R4: in a chain the serial output feeds the next input and two devices need 48 clocks.
// R5: a received low-power command takes effect on the chip-select rise ending the frame.
// R6: the wake output is driven low in normal mode and released high in low-power mode.
// R7: on sleep the shared wake line reads high, and a low seen on it wakes the device.
// R8: a switch change during a low-power frame keeps this device in normal mode.
// R9: after that race the host sends two status frames, the second being valid.
// R10: the host waits 10 to 20 ms between those two status frames; the bench waits 100 cycles (1 us).
// R11: the host acknowledges inputs and rewrites sleep settings before the sleep command.
// R12: internal power-on reset returns normal mode with defaults in every register.
// R13: the host rewrites the configuration periodically in case of an unseen reset.
// R14: a switch closure in low-power mode pulls wake low and returns normal mode.
// R15: the wake cause is latched in a flag the host reads once power returns.
// R16: out of reset the device is in normal mode with switch inputs high impedance.
// R17: each device takes and returns 24 bits per select period, so a chain passes the first 24 on.
`timescale 1ns/1ns
module smsw_seq (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire smsw_pkg::smsw_serial_t i_serial,
  input wire logic i_logic_supply_ok,
  input wire logic i_host_supply_ok,
  input wire smsw_pkg::smsw_switch_t i_switch,
  input wire logic i_wake_in,
  input wire logic i_flag_clear,
  output logic o_sdo,
  output logic o_wake_out,
  output logic o_wake_oe,
  output logic o_low_power,
  output logic o_tristate,
  output logic [1:0] o_wake_cause,
  output logic o_wake_flag
);
  localparam int SYNC_W = 3 + 2 + 1 + smsw_pkg::NUM_SW;
  // idle pin levels as reset value, so no false select, clock or switch edge follows reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {3'b010, 2'b00, 1'b1, {smsw_pkg::NUM_SW{1'b1}}};

  // two-flop synchronisers on every asynchronous input
  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end else begin
      sync1 <= {i_serial, i_logic_supply_ok, i_host_supply_ok, i_wake_in, i_switch};
      sync2 <= sync1;
    end
  end

  logic sclk;
  logic cs_n;
  logic sdi;
  logic vdd_ok;
  logic host_ok;
  logic wake_line;
  logic [smsw_pkg::NUM_SW-1:0] sw_now;
  assign {sclk, cs_n, sdi, vdd_ok, host_ok, wake_line, sw_now} = sync2;

  // edge history of synchronised levels
  logic sclk_d;
  logic cs_n_d;
  logic [smsw_pkg::NUM_SW-1:0] sw_d;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_d <= 1'b0;
      cs_n_d <= 1'b1;
      sw_d <= '1; // open switches idle high
    end else begin
      sclk_d <= sclk;
      cs_n_d <= cs_n;
      sw_d <= sw_now;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic sw_change;
  logic sw_closed;
  assign sclk_rise = sclk & ~sclk_d;
  assign sclk_fall = ~sclk & sclk_d;
  assign cs_fall = ~cs_n & cs_n_d;
  assign cs_rise = cs_n & ~cs_n_d;
  assign sw_change = |(sw_now ^ sw_d);
  assign sw_closed = |(~sw_now & sw_d); // closure pulls an input low

  // serial shift register: 24 bits in, the same 24 bits out
  logic [smsw_pkg::FRAME_BITS-1:0] shreg;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      shreg <= '0;
    end else if (!cs_n && vdd_ok && sclk_rise) begin
      shreg <= {shreg[smsw_pkg::FRAME_BITS-2:0], sdi}; // R17 R4
    end
  end

  // output bit changes on the falling edge so the next device samples it stable
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sdo <= 1'b0;
    end else if (cs_fall) begin
      o_sdo <= shreg[smsw_pkg::FRAME_BITS-1];
    end else if (!cs_n && sclk_fall) begin
      o_sdo <= shreg[smsw_pkg::FRAME_BITS-1]; // R4
    end
  end

  // a switch change inside a selected frame vetoes sleep for that frame
  logic race_seen;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      race_seen <= 1'b0;
    end else if (cs_fall) begin
      race_seen <= 1'b0;
    end else if (!cs_n && sw_change) begin
      race_seen <= 1'b1; // R8
    end
  end

  logic sleep_cmd;
  assign sleep_cmd = shreg[smsw_pkg::CMD_MSB:smsw_pkg::CMD_LSB] == smsw_pkg::CMD_LOW_POWER;

  // our own low drive needs two synchroniser stages to clear from the wake line,
  // so the line is ignored until low power has lasted that long; otherwise the
  // device would wake itself on the cycle after it enters low power
  logic [1:0] lp_hist;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      lp_hist <= 2'b00;
    end else begin
      lp_hist <= {lp_hist[0], o_low_power}; // R7
    end
  end

  // mode machine; the wake line is only trusted once our own drive is released
  smsw_pkg::smsw_mode_t mode;
  smsw_pkg::smsw_mode_t next_mode;
  logic [1:0] next_cause;
  logic wake_sw;
  logic wake_net;
  logic wake_sel;
  assign wake_sw = sw_closed;
  assign wake_net = ~wake_line & lp_hist[1]; // R7
  assign wake_sel = cs_fall & vdd_ok; // R2
  always_comb begin
    next_mode = mode;
    next_cause = smsw_pkg::CAUSE_NONE;
    unique case (mode)
      smsw_pkg::SMSW_NORMAL: begin
        if (cs_rise && vdd_ok && sleep_cmd && !race_seen && !sw_change) begin
          next_mode = smsw_pkg::SMSW_LOW_POWER; // R5 R8
        end
      end
      smsw_pkg::SMSW_LOW_POWER: begin
        if (wake_sw) begin
          next_mode = smsw_pkg::SMSW_NORMAL; // R14
          next_cause = smsw_pkg::CAUSE_SWITCH;
        end else if (wake_sel) begin
          next_mode = smsw_pkg::SMSW_NORMAL; // R1
          next_cause = smsw_pkg::CAUSE_SELECT;
        end else if (wake_net) begin
          next_mode = smsw_pkg::SMSW_NORMAL; // R7
          next_cause = smsw_pkg::CAUSE_SHARED;
        end
      end
      default: begin
        next_mode = smsw_pkg::SMSW_NORMAL;
      end
    endcase
  end

  // reset always lands in normal mode with defaults
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= smsw_pkg::SMSW_NORMAL; // R12 R16
    end else begin
      mode <= next_mode;
    end
  end

  // wake cause flag: a new wake wins over a simultaneous clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wake_flag <= 1'b0;
      o_wake_cause <= smsw_pkg::CAUSE_NONE;
    end else if (next_cause != smsw_pkg::CAUSE_NONE) begin
      o_wake_flag <= 1'b1; // R15
      o_wake_cause <= next_cause;
    end else if (i_flag_clear) begin
      o_wake_flag <= 1'b0;
      o_wake_cause <= smsw_pkg::CAUSE_NONE;
    end
  end

  // switch inputs stay high impedance until configured elsewhere
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_tristate <= smsw_pkg::TRISTATE_RESET; // R16 R12
    end else begin
      o_tristate <= o_tristate;
    end
  end

  // open-drain wake: drive low in normal mode, release to pull-up in low power
  assign o_low_power = (mode == smsw_pkg::SMSW_LOW_POWER);
  assign o_wake_out = 1'b0;
  assign o_wake_oe = ~o_low_power; // R6 R7
  logic unused_host;
  assign unused_host = host_ok; // host supply only explains why a select edge appears

  // mode, wake, flag, shift and tristate checks
  sleep_on_rise_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    (mode == smsw_pkg::SMSW_NORMAL && cs_rise && vdd_ok && sleep_cmd && !race_seen && !sw_change)
      |=> o_low_power)
    else $error("sleep command not taken on select rise");
  race_blocks_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
    (!o_low_power && race_seen && cs_rise) |=> !o_low_power)
    else $error("switch race did not block sleep");
  wake_drive_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
    o_wake_oe == (mode == smsw_pkg::SMSW_NORMAL))
    else $error("wake drive does not follow mode");
  switch_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
    (o_low_power && sw_closed) |=> (!o_low_power && o_wake_oe))
    else $error("switch closure did not wake");
  shared_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
    (o_low_power && $past(o_low_power, 2) && !wake_line) |=> !o_low_power)
    else $error("shared wake line ignored");
  select_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
    (o_low_power && cs_fall && vdd_ok) |=> !o_low_power)
    else $error("select fall did not wake");
  no_serial_wake_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
    (o_low_power && !vdd_ok && wake_line && !sw_closed) |=> o_low_power)
    else $error("woke without logic supply");
  cause_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
    (o_low_power ##1 !o_low_power) |-> (o_wake_flag && o_wake_cause != smsw_pkg::CAUSE_NONE))
    else $error("wake cause not recorded");
  chain_pass_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R17
    (!cs_n && vdd_ok && sclk_rise) |=> shreg[0] == $past(sdi))
    else $error("frame bit not shifted in");
  tristate_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
    o_tristate)
    else $error("switch inputs left high impedance state");

  // wake and mode checks
  blank_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
    ($rose(o_low_power) && !sw_closed && !cs_fall) |=> o_low_power)
    else $error("own wake drive woke the device");
  shared_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
    (o_low_power && $past(o_low_power, 2) && !wake_line && !sw_closed && !(cs_fall && vdd_ok))
      |=> o_wake_cause == smsw_pkg::CAUSE_SHARED)
    else $error("shared wake cause not recorded");
  sleep_on_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    $rose(o_low_power) |-> $past(cs_rise))
    else $error("low power entered without select rise");
  sleep_powered_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
    $rose(o_low_power) |-> $past(vdd_ok))
    else $error("low power entered without logic supply");
  race_latch_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
    (!cs_n && sw_change && !cs_fall) |=> race_seen)
    else $error("switch race not latched");
  race_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R8
    cs_fall |=> !race_seen)
    else $error("race not cleared at frame start");
  switch_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
    (o_low_power && sw_closed) |=> o_wake_cause == smsw_pkg::CAUSE_SWITCH)
    else $error("switch wake cause not recorded");
  select_cause_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
    (o_low_power && cs_fall && vdd_ok && !sw_closed) |=> o_wake_cause == smsw_pkg::CAUSE_SELECT)
    else $error("select wake cause not recorded");

  // flag checks
  flag_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
    (i_flag_clear && !o_low_power) |=> !o_wake_flag)
    else $error("wake flag not cleared");
  flag_sticky_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
    (o_wake_flag && !i_flag_clear) |=> o_wake_flag)
    else $error("wake flag lost without clear");
  cause_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R15
    (!o_low_power && !i_flag_clear) |=> $stable(o_wake_cause))
    else $error("wake cause changed in normal mode");

  // serial path checks
  sdo_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
    cs_fall |=> o_sdo == $past(shreg[smsw_pkg::FRAME_BITS-1]))
    else $error("first output bit not loaded");
  sdo_shift_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
    (!cs_n && sclk_fall) |=> o_sdo == $past(shreg[smsw_pkg::FRAME_BITS-1]))
    else $error("output bit not advanced");
  sdo_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
    cs_n |=> $stable(o_sdo))
    else $error("output moved while deselected");
  shift_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R17
    cs_n |=> $stable(shreg))
    else $error("frame shifted while deselected");
  unpowered_shift_a: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
    !vdd_ok |=> $stable(shreg))
    else $error("frame shifted without logic supply");
endmodule

/* smsw_host.sv */
// smsw_host: host controller model driving the serial link of one device or a chain
// assumes the bench calls send() one frame at a time after reset
`timescale 1ns/1ns
module smsw_host (
  input wire logic i_ref_clk,
  input wire logic i_sdo,
  output smsw_pkg::smsw_serial_t o_serial
);
  // serial clock stands still low and select stays high between frames
  initial begin
    o_serial = 3'b010;
  end
  // 24 bits, or 48 for two chained devices, msb first; one select per frame
  task automatic send(input logic [47:0] data, input bit chain, output logic [47:0] got);
    int n;
    n = chain ? 48 : 24;
    got = '0;
    @(posedge i_ref_clk) #1 o_serial.cs_n = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    for (int i = n - 1; i >= 0; i--) begin
      o_serial.sdi = data[i];
      repeat (4) @(posedge i_ref_clk);
      #1 o_serial.sclk = 1'b1;
      repeat (4) @(posedge i_ref_clk);
      #1 got[i] = i_sdo; // sampled late in the high phase, clear of the edge
      o_serial.sclk = 1'b0;
    end
    repeat (4) @(posedge i_ref_clk);
    #1 o_serial.cs_n = 1'b1;
    o_serial.sdi = ~o_serial.sdi; // released data line must not hold its value
    repeat (4) @(posedge i_ref_clk);
    #1;
  endtask
endmodule

/* switch_monitor_sleep_wake_tb_top.sv */
// testbench for the sleep/wake sequencer: host model plus wake net and switch stimulus
// assumes the wake net has a pull-up and a second monitor may pull it low
`timescale 1ns/1ns
module switch_monitor_sleep_wake_tb_top;
  logic clk, rst, lsup, hsup, fclr, ext_low, sdo, wout, woe, lp, tri_s, flag, wake_net;
  logic [1:0] cause;
  logic [47:0] got;
  smsw_pkg::smsw_switch_t sw;
  smsw_pkg::smsw_serial_t ser;
  int err_total, num_checks;
  // open-drain wake net: driven low by us or by the other monitor
  assign wake_net = (woe ? wout : 1'b1) & ~ext_low;
  smsw_host u_host (.i_ref_clk(clk), .i_sdo(sdo), .o_serial(ser));
  smsw_seq u_dut (.i_ref_clk(clk), .i_rst(rst), .i_serial(ser), .i_logic_supply_ok(lsup),
    .i_host_supply_ok(hsup), .i_switch(sw), .i_wake_in(wake_net), .i_flag_clear(fclr), .o_sdo(sdo),
    .o_wake_out(wout), .o_wake_oe(woe), .o_low_power(lp), .o_tristate(tri_s), .o_wake_cause(cause),
    .o_wake_flag(flag));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] g, input logic [23:0] e, input string what);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic sleep_cmd();
    u_host.send({24'h0, smsw_pkg::CMD_LOW_POWER, 16'h0}, 1'b0, got);
    tick(8);
  endtask
  task automatic woke(input logic [1:0] c);
    chk(lp, 0, "mode");
    chk(woe, 1, "wake oe");
    chk(flag, 1, "flag");
    chk(cause, c, "cause");
  endtask
  // chained sleep frame: first 24 bits pass through, the last 24 carry the sleep command for this device
  task automatic t_chain();
    u_host.send({24'hc3a5f0, smsw_pkg::CMD_LOW_POWER, 16'h1234}, 1'b1, got);
    tick(8);
    chk(got[23:0], 24'hc3a5f0, "chain out");
    chk(lp, 1, "sleep");
    chk(woe, 0, "released");
    chk(wake_net, 1, "net high");
    sw.ground_switch_input[0] = 1'b0;
    tick(8);
    woke(smsw_pkg::CAUSE_SWITCH);
    fclr = 1'b1;
    tick(1);
    fclr = 1'b0;
    tick(2);
    chk(flag, 0, "flag clr");
    sw.ground_switch_input[0] = 1'b1;
  endtask
  // other monitor pulls the net, then a select fall with the host unpowered
  task automatic t_net_sel();
    sleep_cmd();
    ext_low = 1'b1;
    tick(8);
    ext_low = 1'b0;
    woke(smsw_pkg::CAUSE_SHARED);
    hsup = 1'b0;
    sleep_cmd();
    u_host.send(48'h0, 1'b0, got);
    tick(4);
    woke(smsw_pkg::CAUSE_SELECT);
    hsup = 1'b1;
  endtask
  // no logic supply: serial traffic must not wake; internal reset restores normal mode
  task automatic t_supply_reset();
    sleep_cmd();
    lsup = 1'b0;
    u_host.send(48'h0, 1'b0, got);
    lsup = 1'b1;
    tick(8);
    chk(lp, 1, "no serial wake");
    rst = 1'b1;
    tick(2);
    chk({lp, tri_s, flag}, 3'b010, "por");
    rst = 1'b0;
    tick(3);
    u_host.send(48'h0, 1'b0, got);
    chk(lp, 0, "after rewrite");
  endtask
  // switch changes while the sleep frame is in flight; then two status frames
  task automatic t_race();
    fork
      sleep_cmd();
      begin
        tick(60);
        sw.programmable_switch_input[3] = 1'b0;
      end
    join
    chk(lp, 0, "race");
    u_host.send(48'h0, 1'b0, got);
    tick(100); // settle gap, kept short to bound the run
    u_host.send(48'h0, 1'b0, got);
    chk(lp, 0, "stays normal");
    sleep_cmd();
    chk(lp, 1, "resleep");
  endtask
  // watchdog
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    {rst, lsup, hsup, fclr, ext_low} = 5'b11100;
    sw = '1;
    err_total = 0;
    num_checks = 0;
    tick(10);
    chk({lp, woe, tri_s, flag}, 4'b0110, "reset");
    rst = 1'b0;
    tick(3);
    t_chain();
    t_net_sel();
    t_supply_reset();
    t_race();
    conclude();
  end
endmodule
